// ===== verilog/image_unpacker.sv
// Start-up image loader and slave register view for channels 1 to 7
//
// Function
// R1: Byte 14 high nibble to 0x19[3:0], low nibble to 0x1C[5:2].
// R2: Byte 15 copied whole into 0x1D, bit for bit.
// R3: Byte 16 copied whole into 0x1E, bit for bit.
// R4: Byte 17 [7:5] to 0x1F[2:0], [4] to 0x20[7], [3:0] to 0x20[3:0].
// R5: Byte 18 [7:4] to 0x23[5:2], [3:0] to 0x24[7:4].
// R6: Byte 19 [7:4] to 0x24[3:0], [3:0] to 0x25[7:4].
// R7: Byte 20 [7:4] to 0x25[3:0], [3:1] to 0x26[2:0], [0] to 0x27[7].
// R8: Byte 21 [7:4] to 0x27[3:0], [3:0] to 0x28[6:3].
// R9: Byte 22 [7:5] to 0x28[2:0], [4:1] to 0x2B[5:2], [0] to 0x2C[7].
// R10: Byte 23 [7:1] to 0x2C[6:0], [0] to 0x2D[7].
// R11: Byte 24 [7:1] to 0x2D[6:0], [0] to 0x2E[2].
// R12: Byte 25 to 0x2E[1:0], 0x2F[7], 0x2F[3:0], 0x32[5].
// R13: Byte 26 [7:5] to 0x32[4:2], [4:0] to 0x33[7:3].
// R14: Byte 27 [7:5] to 0x33[2:0], [4] to 0x34[7], [3:0] to 0x34[6:3].
// R15: Byte 28 to 0x34[2:0], 0x35[2:0], 0x36[7], 0x36[3].
// R16: Byte 29 [7:5] to 0x36[2:0], [4:1] to 0x39[5:2], [0] to 0x3A[7].
// R17: Bytes 30-32 fill channel 6 like channel 4; byte 32[0] to 0x40[5].
// R18: Bytes 33-36 fill channel 7 like channel 5, then 0x47 and 0x48[7].
// R19: Byte 37 bits scatter into 0x48, 0x4C, 0x4F and 0x59; default zero.
// R20: Bytes 38 and 39 copied whole into 0x5A and 0x5B; default 0x54.
// R21: Default image holds 0x2F, 0xAD, 0x40 for channel 2 bytes.
// R22: Default image holds 0xFA, 0xD4, 0x09 in bytes 19 to 21.
// R23: Low load request starts a memory read; done goes low on success.
// R24: Slot data is 37 bytes, starting at the mapped start address.
// R25: Uncovered bits keep defaults; mapped bits copied exactly, never inverted.
`timescale 1ns/1ps
module image_unpacker
    import image_unpack_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic load_req_n,
    input wire logic [10:0] start_addr,
    input wire logic image_valid,
    input wire logic [7:0] image_data,
    input wire logic image_fail,
    input wire reg_access_t reg_acc,
    output fetch_t fetch,
    output logic load_done_n,
    output logic load_busy,
    output logic load_fail,
    output logic [7:0] reg_rd_data
);

    // ************************************************************
    // Register view
    // ************************************************************
    // Gathers one slave register out of the image store; unmapped bits read zero
    function automatic logic [7:0] read_reg(input logic [6:0] a, input img_t m);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            REG_CH1_IDLE_THRESHOLD: r = {4'h0, m[14][7:4]};
            REG_CH2_IDLE_DETECT_CTRL: r = {2'b00, m[14][3:0], 2'b00};
            REG_CH2_EQUALIZER_SETTING: r = m[15];
            REG_CH2_OUTPUT_CTRL: r = m[16];
            REG_CH2_DEEMPHASIS: r = {5'h00, m[17][7:5]};
            REG_CH2_IDLE_THRESHOLD: r = {m[17][4], 3'b000, m[17][3:0]};
            REG_CH3_IDLE_DETECT_CTRL: r = {2'b00, m[18][7:4], 2'b00};
            REG_CH3_EQUALIZER_SETTING: r = {m[18][3:0], m[19][7:4]};
            REG_CH3_OUTPUT_CTRL: r = {m[19][3:0], m[20][7:4]};
            REG_CH3_DEEMPHASIS: r = {5'h00, m[20][3:1]};
            REG_CH3_IDLE_THRESHOLD: r = {m[20][0], 3'b000, m[21][7:4]};
            REG_FAST_IDLE_GAIN_CTRL: r = {1'b0, m[21][3:0], m[22][7:5]};
            REG_CH4_IDLE_DETECT_CTRL: r = {2'b00, m[22][4:1], 2'b00};
            REG_CH4_EQUALIZER_SETTING: r = {m[22][0], m[23][7:1]};
            REG_CH4_OUTPUT_CTRL: r = {m[23][0], m[24][7:1]};
            REG_CH4_DEEMPHASIS: r = {5'h00, m[24][0], m[25][7:6]};
            REG_CH4_IDLE_THRESHOLD: r = {m[25][5], 3'b000, m[25][4:1]};
            REG_CH5_IDLE_DETECT_CTRL: r = {2'b00, m[25][0], m[26][7:5], 2'b00};
            REG_CH5_EQUALIZER_SETTING: r = {m[26][4:0], m[27][7:5]};
            REG_CH5_OUTPUT_CTRL: r = {m[27][4:0], m[28][7:5]};
            REG_CH5_DEEMPHASIS: r = {5'h00, m[28][4:2]};
            REG_CH5_IDLE_THRESHOLD: r = {m[28][1], 3'b000, m[28][0], m[29][7:5]};
            REG_CH6_IDLE_DETECT_CTRL: r = {2'b00, m[29][4:1], 2'b00};
            REG_CH6_EQUALIZER_SETTING: r = {m[29][0], m[30][7:1]};
            REG_CH6_OUTPUT_CTRL: r = {m[30][0], m[31][7:1]};
            REG_CH6_DEEMPHASIS: r = {5'h00, m[31][0], m[32][7:6]};
            REG_CH6_IDLE_THRESHOLD: r = {m[32][5], 3'b000, m[32][4:1]};
            REG_CH7_IDLE_DETECT_CTRL: r = {2'b00, m[32][0], m[33][7:5], 2'b00};
            REG_CH7_EQUALIZER_SETTING: r = {m[33][4:0], m[34][7:5]};
            REG_CH7_OUTPUT_CTRL: r = {m[34][4:0], m[35][7:5]};
            REG_CH7_DEEMPHASIS: r = {5'h00, m[35][4:2]};
            REG_CH7_IDLE_THRESHOLD: r = {m[35][1], 3'b000, m[35][0], m[36][7:5]};
            REG_HIDDEN_CONFIG_47: r = {4'h0, m[36][4:1]};
            REG_HIDDEN_CONFIG_48: r = {m[36][0], m[37][7], 6'h00};
            REG_HIDDEN_CONFIG_4C: r = {m[37][6], 1'b0, m[37][4:2], 2'b00, m[37][1]};
            REG_HIDDEN_CONFIG_4F: r = {1'b0, m[37][5], 6'h00};
            REG_HIDDEN_CONFIG_59: r = {7'h00, m[37][0]};
            REG_HIDDEN_CONFIG_5A: r = m[38];
            REG_HIDDEN_CONFIG_5B: r = m[39];
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    load_state_t state_q;
    img_t img_q;
    img_t img_wr_d;
    logic [5:0] data_idx_q;
    logic [5:0] byte_no;
    logic [10:0] start_q;
    logic sync1_q, sync2_q, sync3_q;
    logic req_level_q;
    logic req_fall;
    logic load_fire;
    logic load_last;
    logic slave_wr;
    logic [7:0] view_w [0:127];

    // Image byte number of the byte now on image_data
    assign byte_no = data_idx_q + DATA_FIRST_BYTE;
    assign load_fire = clk_en && (state_q == LD_READ) && fetch.req && image_valid && !image_fail;
    assign load_last = (data_idx_q == DATA_LEN - 6'd1);
    // Slave writes are refused while the loader owns the image store
    assign slave_wr = clk_en && reg_acc.wr && (state_q == LD_IDLE);

    // Full register view, shared by the read port and the checks below
    always_comb begin
        for (int a = 0; a < 128; a++) begin
            view_w[a] = read_reg(7'(a), img_q);
        end
    end

    // ************************************************************
    // Load request pin
    // ************************************************************
    // Three-stage synchroniser; a level counts only once stages two and three agree
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            sync3_q <= 1'b1;
            req_level_q <= 1'b1;
        end else if (clk_en) begin
            sync1_q <= load_req_n;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q == sync3_q) begin
                req_level_q <= sync3_q;
            end
        end
    end

    // Falling edge of the filtered request; a request held low from reset also counts
    assign req_fall = req_level_q && (sync2_q == sync3_q) && !sync3_q;

    // ************************************************************
    // Loader sequence
    // ************************************************************
    // R23: master read on request, done low on success
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= LD_IDLE;
            load_done_n <= 1'b1;
            load_busy <= 1'b0;
            load_fail <= 1'b0;
        end else if (clk_en) begin
            unique case (state_q)
                LD_IDLE: begin
                    if (req_fall) begin
                        state_q <= LD_READ;
                        load_done_n <= 1'b1;
                        load_busy <= 1'b1;
                        load_fail <= 1'b0;
                    end
                end
                LD_READ: begin
                    if (fetch.req && image_fail) begin
                        // A failed read leaves done high so the chain does not advance
                        state_q <= LD_IDLE;
                        load_busy <= 1'b0;
                        load_fail <= 1'b1;
                    end else if (load_fire && load_last) begin
                        state_q <= LD_IDLE;
                        load_busy <= 1'b0;
                        load_done_n <= 1'b0;
                    end
                end
            endcase
        end
    end

    // R24: walk 37 bytes from the mapped start address
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            data_idx_q <= 6'd0;
            start_q <= 11'h000;
            fetch <= '0;
        end else if (clk_en) begin
            if (state_q == LD_IDLE && req_fall) begin
                data_idx_q <= 6'd0;
                start_q <= start_addr;
                fetch.req <= 1'b1;
                fetch.addr <= start_addr;
            end else if (state_q == LD_READ && fetch.req && image_fail) begin
                fetch.req <= 1'b0;
            end else if (load_fire) begin
                data_idx_q <= data_idx_q + 6'd1;
                fetch.addr <= fetch.addr + 11'h001;
                fetch.req <= !load_last;
            end
        end
    end

    // ************************************************************
    // Image store
    // ************************************************************
    // R25: a slave write lands only on bits that some image bit feeds
    always_comb begin
        logic [207:0] flat;
        logic [7:0] hit;
        hit = 8'h00;
        flat = img_q;
        for (int k = 0; k < 208; k++) begin
            hit = read_reg(reg_acc.addr, img_t'(208'(1) << k));
            if (hit != 8'h00) begin
                flat[k] = |(hit & reg_acc.wdata);
            end
        end
        img_wr_d = flat;
    end

    // R21: channel 2 power-on bytes
    // R22: channel 3 power-on bytes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            img_q <= IMG_DEFAULT;
        end else if (load_fire) begin
            // R20: bytes 14 to 39 stored whole, no inversion
            if (byte_no >= IMG_FIRST && byte_no <= IMG_LAST) begin
                img_q[byte_no] <= image_data;
            end
        end else if (slave_wr) begin
            img_q <= img_wr_d;
        end
    end

    // Read data follows one cycle after the read strobe and then holds
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rd_data <= 8'h00;
        end else if (clk_en && reg_acc.rd) begin
            reg_rd_data <= view_w[reg_acc.addr];
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_byte14_map: assert property ( // R1
        load_fire && byte_no == 6'd14 |=> {view_w[REG_CH1_IDLE_THRESHOLD][3:0],
        view_w[REG_CH2_IDLE_DETECT_CTRL][5:2]} == $past(image_data))
        else $error("byte 14 misplaced");
    a_byte15_map: assert property ( // R2
        load_fire && byte_no == 6'd15 |=> view_w[REG_CH2_EQUALIZER_SETTING] == $past(image_data))
        else $error("byte 15 misplaced");
    a_byte16_map: assert property ( // R3
        load_fire && byte_no == 6'd16 |=> view_w[REG_CH2_OUTPUT_CTRL] == $past(image_data))
        else $error("byte 16 misplaced");
    a_byte17_map: assert property ( // R4
        load_fire && byte_no == 6'd17 |=> {view_w[REG_CH2_DEEMPHASIS][2:0],
        view_w[REG_CH2_IDLE_THRESHOLD][7], view_w[REG_CH2_IDLE_THRESHOLD][3:0]}
        == $past(image_data)) else $error("byte 17 misplaced");
    a_byte18_map: assert property ( // R5
        load_fire && byte_no == 6'd18 |=> {view_w[REG_CH3_IDLE_DETECT_CTRL][5:2],
        view_w[REG_CH3_EQUALIZER_SETTING][7:4]} == $past(image_data))
        else $error("byte 18 misplaced");
    a_byte19_map: assert property ( // R6
        load_fire && byte_no == 6'd19 |=> {view_w[REG_CH3_EQUALIZER_SETTING][3:0],
        view_w[REG_CH3_OUTPUT_CTRL][7:4]} == $past(image_data)) else $error("byte 19 misplaced");
    a_byte20_map: assert property ( // R7
        load_fire && byte_no == 6'd20 |=> {view_w[REG_CH3_OUTPUT_CTRL][3:0],
        view_w[REG_CH3_DEEMPHASIS][2:0], view_w[REG_CH3_IDLE_THRESHOLD][7]}
        == $past(image_data)) else $error("byte 20 misplaced");
    a_byte21_map: assert property ( // R8
        load_fire && byte_no == 6'd21 |=> {view_w[REG_CH3_IDLE_THRESHOLD][3:0],
        view_w[REG_FAST_IDLE_GAIN_CTRL][6:3]} == $past(image_data)) else $error("byte 21 misplaced");
    a_byte22_map: assert property ( // R9
        load_fire && byte_no == 6'd22 |=> {view_w[REG_FAST_IDLE_GAIN_CTRL][2:0],
        view_w[REG_CH4_IDLE_DETECT_CTRL][5:2], view_w[REG_CH4_EQUALIZER_SETTING][7]}
        == $past(image_data)) else $error("byte 22 misplaced");
    a_byte23_map: assert property ( // R10
        load_fire && byte_no == 6'd23 |=> {view_w[REG_CH4_EQUALIZER_SETTING][6:0],
        view_w[REG_CH4_OUTPUT_CTRL][7]} == $past(image_data)) else $error("byte 23 misplaced");
    a_byte24_map: assert property ( // R11
        load_fire && byte_no == 6'd24 |=> {view_w[REG_CH4_OUTPUT_CTRL][6:0],
        view_w[REG_CH4_DEEMPHASIS][2]} == $past(image_data)) else $error("byte 24 misplaced");
    a_byte25_map: assert property ( // R12
        load_fire && byte_no == 6'd25 |=> {view_w[REG_CH4_DEEMPHASIS][1:0],
        view_w[REG_CH4_IDLE_THRESHOLD][7], view_w[REG_CH4_IDLE_THRESHOLD][3:0],
        view_w[REG_CH5_IDLE_DETECT_CTRL][5]} == $past(image_data))
        else $error("byte 25 misplaced");
    a_byte26_map: assert property ( // R13
        load_fire && byte_no == 6'd26 |=> {view_w[REG_CH5_IDLE_DETECT_CTRL][4:2],
        view_w[REG_CH5_EQUALIZER_SETTING][7:3]} == $past(image_data))
        else $error("byte 26 misplaced");
    a_byte27_map: assert property ( // R14
        load_fire && byte_no == 6'd27 |=> {view_w[REG_CH5_EQUALIZER_SETTING][2:0],
        view_w[REG_CH5_OUTPUT_CTRL][7:3]} == $past(image_data)) else $error("byte 27 misplaced");
    a_byte28_map: assert property ( // R15
        load_fire && byte_no == 6'd28 |=> {view_w[REG_CH5_OUTPUT_CTRL][2:0],
        view_w[REG_CH5_DEEMPHASIS][2:0], view_w[REG_CH5_IDLE_THRESHOLD][7],
        view_w[REG_CH5_IDLE_THRESHOLD][3]} == $past(image_data)) else $error("byte 28 misplaced");
    a_byte29_map: assert property ( // R16
        load_fire && byte_no == 6'd29 |=> {view_w[REG_CH5_IDLE_THRESHOLD][2:0],
        view_w[REG_CH6_IDLE_DETECT_CTRL][5:2], view_w[REG_CH6_EQUALIZER_SETTING][7]}
        == $past(image_data)) else $error("byte 29 misplaced");
    a_byte32_map: assert property ( // R17
        load_fire && byte_no == 6'd32 |=> {view_w[REG_CH6_DEEMPHASIS][1:0],
        view_w[REG_CH6_IDLE_THRESHOLD][7], view_w[REG_CH6_IDLE_THRESHOLD][3:0],
        view_w[REG_CH7_IDLE_DETECT_CTRL][5]} == $past(image_data))
        else $error("byte 32 misplaced");
    a_byte36_map: assert property ( // R18
        load_fire && byte_no == 6'd36 |=> {view_w[REG_CH7_IDLE_THRESHOLD][2:0],
        view_w[REG_HIDDEN_CONFIG_47][3:0], view_w[REG_HIDDEN_CONFIG_48][7]}
        == $past(image_data)) else $error("byte 36 misplaced");
    a_byte37_map: assert property ( // R19
        load_fire && byte_no == 6'd37 |=> {view_w[REG_HIDDEN_CONFIG_48][6],
        view_w[REG_HIDDEN_CONFIG_4C][7], view_w[REG_HIDDEN_CONFIG_4F][6],
        view_w[REG_HIDDEN_CONFIG_4C][5:3], view_w[REG_HIDDEN_CONFIG_4C][0],
        view_w[REG_HIDDEN_CONFIG_59][0]} == $past(image_data)) else $error("byte 37 misplaced");
    a_byte39_map: assert property ( // R20
        load_fire && byte_no == 6'd39 |=> view_w[REG_HIDDEN_CONFIG_5B] == $past(image_data))
        else $error("byte 39 misplaced");
    a_done_after_load: assert property ( // R23
        load_fire && load_last |=> !load_done_n && !load_busy && !fetch.req [*2])
        else $error("done not signalled after last byte");
    a_fetch_address: assert property ( // R24
        fetch.req |-> fetch.addr == start_q + 11'(data_idx_q) && data_idx_q < DATA_LEN)
        else $error("fetch address off slot");
    a_unmapped_zero: assert property ( // R25
        slave_wr && reg_acc.addr > REG_HIDDEN_CONFIG_5B |=> img_q == $past(img_q))
        else $error("unmapped write changed image");

    // A load owns the store: slave writes and a frozen clock leave it alone
    a_write_refused: assert property ( // R23
        reg_acc.wr && load_busy && byte_no != 6'd15 |=> view_w[REG_CH2_EQUALIZER_SETTING]
        == $past(view_w[REG_CH2_EQUALIZER_SETTING])) else $error("write landed during load");
    a_clock_freeze: assert property (
        !clk_en |=> img_q == $past(img_q) && state_q == $past(state_q)
        && reg_rd_data == $past(reg_rd_data)) else $error("state moved while frozen");
    a_load_start: assert property ( // R23
        state_q == LD_IDLE && req_fall && clk_en |=> load_busy && load_done_n && fetch.req
        && fetch.addr == $past(start_addr)) else $error("load did not start");
    a_fail_abort: assert property ( // R23
        fetch.req && image_fail && clk_en |=> load_fail && !load_busy && !fetch.req
        && load_done_n) else $error("failed read not aborted");

    c_load_done: cover property (load_fire && load_last ##1 !load_done_n);
    c_load_failed: cover property (load_busy ##1 load_fail);
    c_back_to_back: cover property (load_fire [*3]);
    c_slave_write: cover property (slave_wr && reg_acc.addr == REG_CH2_EQUALIZER_SETTING);

endmodule

// ===== verilog/image_unpack_pkg.sv
// Shared constants, register offsets and carrier types for the image unpacker
package image_unpack_pkg;

    // ************************************************************
    // Image geometry
    // ************************************************************
    localparam logic [5:0] DATA_LEN = 6'd37;         // Device data bytes per slot
    localparam logic [5:0] DATA_FIRST_BYTE = 6'd3;   // Image byte number of first data byte
    localparam logic [5:0] IMG_FIRST = 6'd14;        // First image byte held here
    localparam logic [5:0] IMG_LAST = 6'd39;         // Last image byte held here

    // Image store, indexed by image byte number
    typedef logic [39:14][7:0] img_t;

    // Power-on image for bytes 14 up to 39
    localparam img_t IMG_DEFAULT = {
        8'h54, 8'h54, 8'h00, 8'h00, 8'ha8, 8'hf5, 8'h05, 8'h80, 8'h5a,
        8'h5f, 8'h00, 8'ha8, 8'hf5, 8'h05, 8'h80, 8'h5a, 8'h5f, 8'h80,
        8'h09, 8'hd4, 8'hfa, 8'h02, 8'h40, 8'had, 8'h2f, 8'h00};

    // ************************************************************
    // Slave register offsets
    // ************************************************************
    localparam logic [6:0] REG_CH1_IDLE_THRESHOLD = 7'h19;
    localparam logic [6:0] REG_CH2_IDLE_DETECT_CTRL = 7'h1c;
    localparam logic [6:0] REG_CH2_EQUALIZER_SETTING = 7'h1d;
    localparam logic [6:0] REG_CH2_OUTPUT_CTRL = 7'h1e;
    localparam logic [6:0] REG_CH2_DEEMPHASIS = 7'h1f;
    localparam logic [6:0] REG_CH2_IDLE_THRESHOLD = 7'h20;
    localparam logic [6:0] REG_CH3_IDLE_DETECT_CTRL = 7'h23;
    localparam logic [6:0] REG_CH3_EQUALIZER_SETTING = 7'h24;
    localparam logic [6:0] REG_CH3_OUTPUT_CTRL = 7'h25;
    localparam logic [6:0] REG_CH3_DEEMPHASIS = 7'h26;
    localparam logic [6:0] REG_CH3_IDLE_THRESHOLD = 7'h27;
    localparam logic [6:0] REG_FAST_IDLE_GAIN_CTRL = 7'h28;
    localparam logic [6:0] REG_CH4_IDLE_DETECT_CTRL = 7'h2b;
    localparam logic [6:0] REG_CH4_EQUALIZER_SETTING = 7'h2c;
    localparam logic [6:0] REG_CH4_OUTPUT_CTRL = 7'h2d;
    localparam logic [6:0] REG_CH4_DEEMPHASIS = 7'h2e;
    localparam logic [6:0] REG_CH4_IDLE_THRESHOLD = 7'h2f;
    localparam logic [6:0] REG_CH5_IDLE_DETECT_CTRL = 7'h32;
    localparam logic [6:0] REG_CH5_EQUALIZER_SETTING = 7'h33;
    localparam logic [6:0] REG_CH5_OUTPUT_CTRL = 7'h34;
    localparam logic [6:0] REG_CH5_DEEMPHASIS = 7'h35;
    localparam logic [6:0] REG_CH5_IDLE_THRESHOLD = 7'h36;
    localparam logic [6:0] REG_CH6_IDLE_DETECT_CTRL = 7'h39;
    localparam logic [6:0] REG_CH6_EQUALIZER_SETTING = 7'h3a;
    localparam logic [6:0] REG_CH6_OUTPUT_CTRL = 7'h3b;
    localparam logic [6:0] REG_CH6_DEEMPHASIS = 7'h3c;
    localparam logic [6:0] REG_CH6_IDLE_THRESHOLD = 7'h3d;
    localparam logic [6:0] REG_CH7_IDLE_DETECT_CTRL = 7'h40;
    localparam logic [6:0] REG_CH7_EQUALIZER_SETTING = 7'h41;
    localparam logic [6:0] REG_CH7_OUTPUT_CTRL = 7'h42;
    localparam logic [6:0] REG_CH7_DEEMPHASIS = 7'h43;
    localparam logic [6:0] REG_CH7_IDLE_THRESHOLD = 7'h44;
    localparam logic [6:0] REG_HIDDEN_CONFIG_47 = 7'h47;
    localparam logic [6:0] REG_HIDDEN_CONFIG_48 = 7'h48;
    localparam logic [6:0] REG_HIDDEN_CONFIG_4C = 7'h4c;
    localparam logic [6:0] REG_HIDDEN_CONFIG_4F = 7'h4f;
    localparam logic [6:0] REG_HIDDEN_CONFIG_59 = 7'h59;
    localparam logic [6:0] REG_HIDDEN_CONFIG_5A = 7'h5a;
    localparam logic [6:0] REG_HIDDEN_CONFIG_5B = 7'h5b;

    // ************************************************************
    // Carriers and states
    // ************************************************************
    // Slave-side register access from the serial slave engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_access_t;

    // Byte fetch request toward the configuration memory reader
    typedef struct packed {
        logic req;
        logic [10:0] addr;
    } fetch_t;

    typedef enum logic [0:0] {LD_IDLE, LD_READ} load_state_t;

endpackage

// ===== test/cfg_memory.sv
// Behavioural configuration memory answering the loader's byte fetches
`timescale 1ns/1ps
module cfg_memory
    import image_unpack_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire fetch_t fetch,
    input wire logic [10:0] slot_base,
    input wire logic [7:0] fill,
    input wire logic slow,
    input wire logic fail_now,
    output logic image_valid,
    output logic [7:0] image_data,
    output logic image_fail
);
    logic [1:0] wait_q;
    // answer only a pending fetch; slot bytes hold fill, others its inverse
    // Idle data toggles so a stale byte never looks like a fresh one
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            image_valid <= 1'b0;
            image_fail <= 1'b0;
            image_data <= 8'h5a;
            wait_q <= 2'h0;
        end else begin
            image_valid <= 1'b0;
            image_fail <= 1'b0;
            image_data <= ~image_data;
            if (fetch.req && !image_valid && !image_fail) begin
                if (wait_q != 2'h0) begin
                    wait_q <= wait_q - 2'h1;
                end else begin
                    wait_q <= slow ? 2'h3 : 2'h0;
                    image_fail <= fail_now;
                    image_valid <= !fail_now;
                    image_data <= (fetch.addr - slot_base < 11'd37) ? fill : ~fill;
                end
            end
        end
    end
endmodule

// ===== test/tb.sv
// Self-checking bench: power-on view, slave writes, aborted and full loads
`timescale 1ns/1ps
module tb;
    import image_unpack_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic load_req_n = 1'b1;
    logic clk_en = 1'b1;
    logic [10:0] start_addr = 11'h1f4;
    logic [7:0] fill = 8'hff;
    logic slow = 1'b0;
    logic fail_now = 1'b0;
    reg_access_t reg_acc = '0;
    fetch_t fetch;
    logic image_valid, image_fail, load_done_n, load_busy, load_fail;
    logic [7:0] image_data, reg_rd_data;
    int error_cnt = 0;
    int total_checks = 0;
    // Address and mapped-bit mask of every register the image reaches
    localparam logic [15:0] MASKS [39] = '{16'h190f, 16'h1c3c, 16'h1dff, 16'h1eff, 16'h1f07,
        16'h208f, 16'h233c, 16'h24ff, 16'h25ff, 16'h2607, 16'h278f, 16'h287f, 16'h2b3c,
        16'h2cff, 16'h2dff, 16'h2e07, 16'h2f8f, 16'h323c, 16'h33ff, 16'h34ff, 16'h3507,
        16'h368f, 16'h393c, 16'h3aff, 16'h3bff, 16'h3c07, 16'h3d8f, 16'h403c, 16'h41ff,
        16'h42ff, 16'h4307, 16'h448f, 16'h470f, 16'h48c0, 16'h4cb9, 16'h4f40, 16'h5901,
        16'h5aff, 16'h5bff};
    // Register view of the power-on image
    localparam logic [15:0] DEFS [12] = '{16'h1d2f, 16'h1ead, 16'h1f02, 16'h2000, 16'h242f,
        16'h25ad, 16'h2602, 16'h284c, 16'h5a54, 16'h5b54, 16'h4c00, 16'h1900};

    always #2 ref_clk = ~ref_clk;

    image_unpacker u_dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
        .load_req_n(load_req_n), .start_addr(start_addr), .image_valid(image_valid),
        .image_data(image_data), .image_fail(image_fail), .reg_acc(reg_acc), .fetch(fetch),
        .load_done_n(load_done_n), .load_busy(load_busy), .load_fail(load_fail),
        .reg_rd_data(reg_rd_data));
    cfg_memory u_mem (.ref_clk(ref_clk), .resetn(resetn), .fetch(fetch),
        .slot_base(start_addr), .fill(fill), .slow(slow), .fail_now(fail_now),
        .image_valid(image_valid), .image_data(image_data), .image_fail(image_fail));

    // ************************************************************
    // Access tasks
    // ************************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [6:0] addr, input logic [7:0] wd);
        @(posedge ref_clk) #1 reg_acc = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: wd};
        @(posedge ref_clk) #1 reg_acc = '0;
    endtask
    task automatic reg_rd(input logic [6:0] addr, input logic [7:0] exp);
        @(posedge ref_clk) #1 reg_acc = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge ref_clk) #1 reg_acc = '0;
        check(reg_rd_data, exp);
    endtask
    // Busy must rise within a few edges; a full slow load fits well inside 400
    task automatic load(input logic [7:0] f, input logic s, input logic fl);
        int n;
        fill = f;
        slow = s;
        fail_now = fl;
        load_req_n = 1'b0;
        n = 0;
        while (load_busy !== 1'b1 && n < 20) begin
            @(posedge ref_clk) #1 n++;
        end
        while (load_busy !== 1'b0 && n < 400) begin
            @(posedge ref_clk) #1 n++;
        end
        check(load_done_n, fl);
        check(load_fail, fl);
        load_req_n = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Test sequence and watchdog
    // ************************************************************
    initial begin
        repeat (6) @(posedge ref_clk);
        #1 resetn = 1'b1;
        foreach (DEFS[i]) reg_rd(DEFS[i][14:8], DEFS[i][7:0]);
        reg_wr(7'h19, 8'hff);
        reg_rd(7'h19, 8'h0f);
        reg_wr(7'h1d, 8'h12);
        reg_rd(7'h1d, 8'h12);
        // A write while the clock enable is low must not land
        clk_en = 1'b0;
        reg_wr(7'h1d, 8'h34);
        clk_en = 1'b1;
        reg_rd(7'h1d, 8'h12);
        reg_wr(7'h7f, 8'hff);
        reg_rd(7'h7f, 8'h00);
        load(8'hff, 1'b0, 1'b1);
        load(8'hff, 1'b1, 1'b0);
        foreach (MASKS[i]) reg_rd(MASKS[i][14:8], MASKS[i][7:0]);
        // A slave write in mid-load, after byte 15 is stored, must be refused
        fork
            load(8'h00, 1'b0, 1'b0);
            begin
                repeat (60) @(posedge ref_clk);
                reg_wr(7'h1d, 8'h77);
            end
        join
        foreach (MASKS[i]) reg_rd(MASKS[i][14:8], 8'h00);
        summarize();
    end
    // Whole run needs under 2000 cycles; 20000 cycles means a hang
    initial begin
        #80000;
        error_cnt++;
        summarize();
    end
endmodule
